// File: design/asr_pkg.sv
// Constants, types and helpers shared by the serial receiver files
package asr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_BAUD     = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_DATA     = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_STS  = 8'h10;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W          = 7;
  localparam int unsigned CTRL_PORT_EN    = 0;
  localparam int unsigned CTRL_RX_EN      = 1;
  localparam int unsigned CTRL_SYNC_SEL   = 2;
  localparam int unsigned CTRL_NINE       = 3;
  localparam int unsigned CTRL_RX_IE      = 4;
  localparam int unsigned CTRL_PERIPH_IE  = 5;
  localparam int unsigned CTRL_GLOBAL_IE  = 6;
  localparam logic [6:0]  CTRL_RST        = 7'h00;

  localparam int unsigned BAUD_W   = 16;
  localparam logic [15:0] BAUD_RST = 16'h0035;

  localparam int unsigned STS_PENDING = 0;
  localparam int unsigned STS_FERR    = 1;
  localparam int unsigned STS_OVERRUN = 2;
  localparam int unsigned STS_IDLE    = 3;
  localparam int unsigned STS_NINTH   = 4;

  localparam int unsigned DATA_FERR   = 9;

  localparam int unsigned EV_W    = 3;
  localparam int unsigned EV_CHAR = 0;
  localparam int unsigned EV_FERR = 1;
  localparam int unsigned EV_OVR  = 2;
  localparam logic [2:0]  EV_RST  = 3'h0;

  // ----------------------------------------------------------------
  // Bit timing in sample ticks, data bit counts and FIFO depth
  // ----------------------------------------------------------------
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0]  HALF_BIT   = 4'h7;
  localparam logic [3:0]  SMP_A      = 4'hD;
  localparam logic [3:0]  SMP_B      = 4'hE;
  localparam logic [3:0]  SMP_C      = 4'hF;
  localparam logic [3:0]  BITS_EIGHT = 4'h8;
  localparam logic [3:0]  BITS_NINE  = 4'h9;

  localparam int unsigned FIFO_DEPTH = 2;
  localparam logic [1:0]  FIFO_FULL  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [1:0]  asr_cnt_t;
  typedef logic [0:0]  asr_ptr_t;
  typedef logic [3:0]  asr_sub_t;
  typedef logic [15:0] asr_baud_t;
  typedef logic [31:0] asr_word_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_e;

  typedef struct packed {
    logic       ferr;
    logic [8:0] data;
  } asr_char_s;

  typedef struct packed {
    asr_char_s [FIFO_DEPTH-1:0] mem;
    asr_char_s                  rdata;
  } asr_mem_s;

  typedef struct packed {
    logic [6:0]  ctrl;
    asr_baud_t   baud;
    asr_baud_t   div;
    logic        tick;
    logic        rx_prev;
    asr_rx_e     st;
    asr_sub_t    sub;
    logic [3:0]  bitn;
    logic [1:0]  samp;
    logic [8:0]  shreg;
    logic        overrun;
    asr_ptr_t    wr_ptr;
    asr_ptr_t    rd_ptr;
    asr_cnt_t    count;
    logic [2:0]  irq_sts;
    logic [2:0]  irq_mask;
    logic        pready;
    logic        pslverr;
    asr_word_t   prdata;
    logic        irq;
    logic        pending;
    logic        idle;
  } asr_rx_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic majority(input logic a, input logic b, input logic c);
    majority = (a & b) | (a & c) | (b & c);
  endfunction

endpackage

// File: design/asr_fifo_mem.sv
// Two-entry character store with registered read data
`timescale 1ns/1ns
module asr_fifo_mem (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Write port
  input  wire logic              we,
  input  wire asr_pkg::asr_ptr_t waddr,
  input  wire asr_pkg::asr_char_s wdata,
  // Read port
  input  wire asr_pkg::asr_ptr_t raddr,
  output asr_pkg::asr_char_s     rdata
);

  asr_pkg::asr_mem_s q;
  asr_pkg::asr_mem_s next_q;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (we) begin
      next_q.mem[waddr] = wdata;
    end
    // Forward a write to the slot being read so a fresh head is never stale
    if (we && (waddr == raddr)) begin
      next_q.rdata = wdata;
    end else begin
      next_q.rdata = q.mem[raddr];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;

endmodule

// File: design/asr_receiver.sv
// Asynchronous serial receiver with APB registers and interrupt
`timescale 1ns/1ns
module asr_receiver (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Serial line
  input  wire logic             serial_input_pin,
  // Status and interrupt
  output logic                  receive_pending_flag,
  output logic                  rx_idle,
  output logic                  irq
);

  asr_pkg::asr_rx_s   q;
  asr_pkg::asr_rx_s   next_q;

  logic               mem_we;
  asr_pkg::asr_char_s mem_wdata;
  asr_pkg::asr_char_s mem_rdata;

  logic               rx_on;
  logic               acc;
  logic               push;
  logic               pop;
  logic               bit_val;
  logic [2:0]         ev;
  logic [2:0]         rd_clear;
  logic [3:0]         nbits;
  asr_pkg::asr_char_s done_char;

  // ----------------------------------------------------------------
  // Character store
  // ----------------------------------------------------------------
  asr_fifo_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .waddr   (q.wr_ptr),
    .wdata   (mem_wdata),
    .raddr   (q.rd_ptr),
    .rdata   (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q    = q;
    next_q.tick = 1'b0;
    mem_we    = 1'b0;
    mem_wdata = '0;
    push      = 1'b0;
    pop       = 1'b0;
    bit_val   = 1'b0;
    ev        = '0;
    rd_clear  = '0;
    done_char = '0;

    rx_on = q.ctrl[asr_pkg::CTRL_PORT_EN] & q.ctrl[asr_pkg::CTRL_RX_EN]
          & ~q.ctrl[asr_pkg::CTRL_SYNC_SEL];
    nbits = q.ctrl[asr_pkg::CTRL_NINE] ? asr_pkg::BITS_NINE : asr_pkg::BITS_EIGHT;

    // ----------------------------------------------------------------
    // Sample-tick divider
    // ----------------------------------------------------------------
    // One tick per sixteenth of a bit; the divider only runs with the port on
    if (!q.ctrl[asr_pkg::CTRL_PORT_EN]) begin
      next_q.div = '0;
    end else if (q.div >= q.baud) begin
      next_q.div  = '0;
      next_q.tick = 1'b1;
    end else begin
      next_q.div = asr_pkg::asr_baud_t'(q.div + 16'h0001);
    end

    // ----------------------------------------------------------------
    // Receive state machine
    // ----------------------------------------------------------------
    next_q.rx_prev = serial_input_pin;
    if (!rx_on) begin
      next_q.st = asr_pkg::RX_IDLE;
    end else begin
      unique case (q.st)
        asr_pkg::RX_IDLE: begin
          // A receiver stuck in overrun ignores the line entirely
          if (q.rx_prev && !serial_input_pin && !q.overrun) begin
            next_q.st  = asr_pkg::RX_START;
            next_q.sub = '0;
          end
        end
        asr_pkg::RX_START: begin
          if (q.tick) begin
            if (q.sub == asr_pkg::HALF_BIT) begin
              next_q.sub  = '0;
              next_q.bitn = '0;
              if (serial_input_pin) begin
                next_q.st = asr_pkg::RX_IDLE;
              end else begin
                next_q.st = asr_pkg::RX_DATA;
              end
            end else begin
              next_q.sub = asr_pkg::asr_sub_t'(q.sub + 4'h1);
            end
          end
        end
        asr_pkg::RX_DATA, asr_pkg::RX_STOP: begin
          if (q.tick) begin
            // Sub counter wraps at sixteen, so each centre is one bit apart
            next_q.sub = asr_pkg::asr_sub_t'(q.sub + 4'h1);
            if (q.sub == asr_pkg::SMP_A) begin
              next_q.samp[0] = serial_input_pin;
            end
            if (q.sub == asr_pkg::SMP_B) begin
              next_q.samp[1] = serial_input_pin;
            end
            if (q.sub == asr_pkg::SMP_C) begin
              bit_val = asr_pkg::majority(q.samp[0], q.samp[1], serial_input_pin);
              if (q.st == asr_pkg::RX_DATA) begin
                // Shift register moves only once per bit
                next_q.shreg = {bit_val, q.shreg[8:1]};
                next_q.bitn  = q.bitn + 4'h1;
                if ((q.bitn + 4'h1) == nbits) begin
                  next_q.st = asr_pkg::RX_STOP;
                end
              end else begin
                done_char.ferr = ~bit_val;
                done_char.data = q.ctrl[asr_pkg::CTRL_NINE] ? q.shreg : {1'b0, q.shreg[8:1]};
                next_q.st      = asr_pkg::RX_IDLE;
                ev[asr_pkg::EV_CHAR] = 1'b1;
                ev[asr_pkg::EV_FERR] = ~bit_val;
                if (q.count == asr_pkg::FIFO_FULL) begin
                  // Newest character is dropped; the two held ones survive
                  next_q.overrun      = 1'b1;
                  ev[asr_pkg::EV_OVR] = 1'b1;
                end else begin
                  push = 1'b1;
                end
              end
            end
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // APB access phase
    // ----------------------------------------------------------------
    // Answer one cycle into the access phase so all outputs stay registered
    acc            = psel & penable & ~q.pready;
    next_q.pready  = acc;
    next_q.pslverr = 1'b0;
    next_q.prdata  = '0;
    if (acc) begin
      if (pwrite) begin
        unique case (paddr)
          asr_pkg::OFF_CTRL: begin
            next_q.ctrl = pwdata[asr_pkg::CTRL_W-1:0];
            // Dropping receive enable is how software leaves overrun
            if (!pwdata[asr_pkg::CTRL_RX_EN]) begin
              next_q.overrun = 1'b0;
            end
          end
          asr_pkg::OFF_BAUD: begin
            next_q.baud = pwdata[asr_pkg::BAUD_W-1:0];
          end
          asr_pkg::OFF_IRQ_MASK: begin
            next_q.irq_mask = pwdata[asr_pkg::EV_W-1:0];
          end
          asr_pkg::OFF_STATUS, asr_pkg::OFF_DATA, asr_pkg::OFF_IRQ_STS: begin
            // Read-only; pending flag cannot be forced by software
            next_q.pslverr = 1'b0;
          end
          default: begin
            next_q.pslverr = 1'b1;
          end
        endcase
      end else begin
        unique case (paddr)
          asr_pkg::OFF_CTRL: begin
            next_q.prdata[asr_pkg::CTRL_W-1:0] = q.ctrl;
          end
          asr_pkg::OFF_BAUD: begin
            next_q.prdata[asr_pkg::BAUD_W-1:0] = q.baud;
          end
          asr_pkg::OFF_STATUS: begin
            next_q.prdata[asr_pkg::STS_PENDING] = q.pending;
            next_q.prdata[asr_pkg::STS_FERR]    = (q.count != '0) & mem_rdata.ferr;
            next_q.prdata[asr_pkg::STS_NINTH]   = (q.count != '0) & mem_rdata.data[8];
            next_q.prdata[asr_pkg::STS_OVERRUN] = q.overrun;
            next_q.prdata[asr_pkg::STS_IDLE]    = q.idle;
          end
          asr_pkg::OFF_DATA: begin
            // The only window onto whole received characters
            if (q.count != '0) begin
              next_q.prdata[8:0]                = mem_rdata.data;
              next_q.prdata[asr_pkg::DATA_FERR] = mem_rdata.ferr;
              pop = 1'b1;
            end
          end
          asr_pkg::OFF_IRQ_STS: begin
            next_q.prdata[asr_pkg::EV_W-1:0] = q.irq_sts;
            rd_clear = q.irq_sts;
          end
          asr_pkg::OFF_IRQ_MASK: begin
            next_q.prdata[asr_pkg::EV_W-1:0] = q.irq_mask;
          end
          default: begin
            next_q.pslverr = 1'b1;
          end
        endcase
      end
    end

    // ----------------------------------------------------------------
    // FIFO pointers
    // ----------------------------------------------------------------
    // Push and pop may coincide; the count then holds
    if (push) begin
      mem_we        = 1'b1;
      mem_wdata     = done_char;
      next_q.wr_ptr = asr_pkg::asr_ptr_t'(q.wr_ptr + 1'b1);
    end
    if (pop) begin
      next_q.rd_ptr = asr_pkg::asr_ptr_t'(q.rd_ptr + 1'b1);
    end
    unique case ({push, pop})
      2'b10:   next_q.count = asr_pkg::asr_cnt_t'(q.count + 2'h1);
      2'b01:   next_q.count = asr_pkg::asr_cnt_t'(q.count - 2'h1);
      default: next_q.count = q.count;
    endcase

    // ----------------------------------------------------------------
    // Flags and interrupt
    // ----------------------------------------------------------------
    // A new event in the clearing read's cycle is kept
    next_q.irq_sts = (q.irq_sts & ~rd_clear) | ev;
    next_q.pending = (next_q.count != '0) & rx_on;
    next_q.idle    = (next_q.st == asr_pkg::RX_IDLE);
    next_q.irq     = (q.pending & q.ctrl[asr_pkg::CTRL_RX_IE]
                   & q.ctrl[asr_pkg::CTRL_PERIPH_IE] & q.ctrl[asr_pkg::CTRL_GLOBAL_IE])
                   | (|(q.irq_sts & q.irq_mask));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.ctrl     <= asr_pkg::CTRL_RST;
      q.baud     <= asr_pkg::BAUD_RST;
      q.rx_prev  <= 1'b1;
      q.st       <= asr_pkg::RX_IDLE;
      q.irq_sts  <= asr_pkg::EV_RST;
      q.irq_mask <= asr_pkg::EV_RST;
      q.idle     <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata               = q.prdata;
  assign pready               = q.pready;
  assign pslverr              = q.pslverr;
  assign receive_pending_flag = q.pending;
  assign rx_idle              = q.idle;
  assign irq                  = q.irq;

endmodule

// File: verification/asr_properties.sv
// Port-level concurrent checks for the serial receiver
`timescale 1ns/1ns
module asr_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial line and status
  input wire logic        serial_input_pin,
  input wire logic        receive_pending_flag,
  input wire logic        rx_idle,
  input wire logic        irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  sequence s_start_seen; $fell(rx_idle); endsequence

  property p_wait_state; s_access |=> s_answer; endproperty
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  property p_err_map;
    pready |-> (pslverr == ($past(paddr) > 8'h14 || $past(paddr[1:0]) != 2'h0));
  endproperty
  property p_err_qual; pslverr |-> pready; endproperty
  property p_rdata_quiet; !pready |-> prdata == 32'h0000_0000; endproperty
  property p_reset_vals; $rose(presetn) |-> rx_idle && !pready && !irq && !receive_pending_flag; endproperty
  // Busy only follows a low line, since idle is sampled behind a register
  property p_idle_cause;
    s_start_seen |-> !$past(serial_input_pin) || !$past(serial_input_pin, 2) || !$past(serial_input_pin, 3);
  endproperty
  // Half a bit is at least eight sample ticks, each at least one clock
  property p_busy_min; s_start_seen |=> !rx_idle [*6]; endproperty

  a_wait_state:  assert property (p_wait_state) else $error("access not answered next cycle");
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  a_err_map:     assert property (p_err_map) else $error("pslverr does not match address map");
  a_err_qual:    assert property (p_err_qual) else $error("pslverr without pready");
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer");
  a_reset_vals:  assert property (p_reset_vals) else $error("wrong values after reset");
  a_idle_cause:  assert property (p_idle_cause) else $error("busy without falling line");
  a_busy_min:    assert property (p_busy_min) else $error("start check too early");
endmodule

bind asr_receiver asr_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_input_pin(serial_input_pin),
  .receive_pending_flag(receive_pending_flag), .rx_idle(rx_idle), .irq(irq)
);

// File: verification/asr_serial_tx.sv
// Remote asynchronous transmitter driving the receive line
`timescale 1ns/1ns
module asr_serial_tx #(
  parameter int BIT_CYC = 16
) (
  // Clock and line
  input  wire logic pclk,
  output logic      line
);
  // Idle mark level, as the pulled-up input pin rests
  initial line = 1'b1;

  // Caller enters just after a rising edge
  task automatic send(input logic [8:0] d, input int nb, input logic stop_v, input int start_len);
    line <= 1'b0;
    repeat (start_len) @(posedge pclk);
    if (start_len < BIT_CYC) begin
      line <= 1'b1;
    end else begin
      for (int i = 0; i < nb; i++) begin
        line <= d[i];
        repeat (BIT_CYC) @(posedge pclk);
      end
      line <= stop_v;
      repeat (BIT_CYC) @(posedge pclk);
      line <= 1'b1;
    end
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ns
module testbench;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rx_line, pend, idle, irq, err;
  logic [8:0]  d;
  int          n_errors, compares, ev, q[$];
  bit          ovr;
  logic [31:0] cfg[4] = '{32'h73, 32'h63, 32'h53, 32'h33};

  asr_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_input_pin(rx_line), .receive_pending_flag(pend), .rx_idle(idle), .irq(irq));
  asr_serial_tx tx (.pclk(pclk), .line(rx_line));

  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Values read at the edge are the ones held before it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    // Let one edge pass so a release and the next setup never share a time step
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  function automatic logic [31:0] stat();
    int s;
    s = 8 | (ovr << 2);
    if (q.size() != 0)
      s = s | 1 | (((q[0] >> 9) & 1) << 1) | (((q[0] >> 8) & 1) << 4);
    return 32'(s);
  endfunction

  // Model: two entries, a third completing character sets overrun and is lost
  task automatic sendc(input logic [8:0] v, input int nb, input logic s);
    tx.send(v, nb, s, 16);
    if (!ovr && q.size() == 2) begin
      ovr = 1;
      ev = ev | 4;
    end else if (!ovr) begin
      q.push_back(int'({~s, v}));
      ev = ev | (s ? 1 : 3);
    end
    repeat (4) @(posedge pclk);
  endtask

  task automatic popc();
    int e;
    e = 0;
    if (q.size() != 0)
      e = q.pop_front();
    rdc(asr_pkg::OFF_DATA, 32'(e));
  endtask

  task automatic evc();
    rdc(asr_pkg::OFF_IRQ_STS, 32'(ev));
    ev = 0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(37));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(asr_pkg::OFF_CTRL, 32'h0000_0000);
    rdc(asr_pkg::OFF_BAUD, 32'h0000_0035);
    rdc(asr_pkg::OFF_STATUS, stat());
    rdc(8'h18, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, asr_pkg::OFF_BAUD, 32'h0000_0000);
    // One enable wrong at a time: nothing is received
    for (int k = 1; k < 4; k++) begin
      apb(1'b1, asr_pkg::OFF_CTRL, (k == 3) ? 32'h7 : 32'(k));
      tx.send(9'h055, 8, 1'b1, 16);
      repeat (4) @(posedge pclk);
      chk(pend, 1'b0);
    end
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h0000_0003);
    apb(1'b1, asr_pkg::OFF_STATUS, 32'h0000_001F);
    chk(pend, 1'b0);
    for (int k = 0; k < 2; k++) begin
      d = {1'b0, 8'($urandom)};
      sendc(d, 8, 1'b1);
    end
    chk(pend, 1'b1);
    rdc(asr_pkg::OFF_STATUS, stat());
    fork
      sendc({1'b0, 8'($urandom)}, 8, 1'b1);
      begin
        repeat (60) @(posedge pclk);
        popc();
      end
    join
    popc();
    popc();
    popc();
    chk(pend, 1'b0);
    // Bad stop bit flags an error, then a good one reads back without it
    sendc({1'b0, 8'($urandom)}, 8, 1'b0);
    rdc(asr_pkg::OFF_STATUS, stat());
    evc();
    popc();
    sendc({1'b0, 8'($urandom)}, 8, 1'b1);
    popc();
    // Runt start bit is dropped quietly
    tx.send(9'h000, 8, 1'b1, 5);
    repeat (20) @(posedge pclk);
    chk(idle, 1'b1);
    rdc(asr_pkg::OFF_STATUS, stat());
    evc();
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h0000_000B);
    sendc(9'($urandom), 9, 1'b1);
    rdc(asr_pkg::OFF_STATUS, stat());
    popc();
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h0000_0003);
    // Fill past two entries; the fourth must not be taken either
    for (int k = 0; k < 4; k++)
      sendc({1'b0, 8'($urandom)}, 8, 1'b1);
    rdc(asr_pkg::OFF_STATUS, stat());
    evc();
    popc();
    popc();
    popc();
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h0000_0001);
    ovr = 0;
    apb(1'b1, asr_pkg::OFF_CTRL, 32'h0000_0003);
    sendc({1'b0, 8'($urandom)}, 8, 1'b1);
    rdc(asr_pkg::OFF_STATUS, stat());
    evc();
    // Pending interrupt needs all three enables
    sendc({1'b0, 8'($urandom)}, 8, 1'b1);
    foreach (cfg[k]) begin
      apb(1'b1, asr_pkg::OFF_CTRL, cfg[k]);
      repeat (3) @(posedge pclk);
      chk(irq, k == 0);
    end
    apb(1'b1, asr_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    evc();
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, asr_pkg::OFF_DATA, 32'h0000_01FF);
    popc();
    popc();
    end_sim();
  end
endmodule
